// ==== hdl/label_applicator_sequencer.sv ====
// Pneumatic label applicator sequencer with an APB register file.
// Assumes sensor and labeler inputs change slowly against pclk.
//
// Notes on behaviour
// - Software picks the applicator type; direct labelling after reset.
// - Sensor-limited tamp stops at touchdown; its vacuum holds the label meanwhile.
// - Timed tamp stays extended for the dwell time, then retracts home.
// - Timed tamp with blow blows after dwell, retracts after blow time.
// - Sensor-terminated tamp blows (if blow time is set) or retracts on touchdown, not after the dwell time.
// - Reverse type parks extended; start blows, retracts, dispenses, parks again.
// - Blow-on type blows the label across without any cylinder stroke.
// - Dwell, blow, restart and position timers apply per fixed type table.
// - Status select maps lines to vacuum/blow or dispense-end/warning.
// - Dispense-first: each accepted start dispenses and then applies a label.
// - Start-first: start applies the waiting label, then the next dispenses.
// - Dwell 1..99999 ms, default 200 or 500; own output while extended.
// - Blow time 0..99999 ms, default 50, or 60 for the air blow type.
// - Starts are ignored for the restart delay after each application.
// - Missing an end position within the position timeout flags an error.
// - Stroke compensation delay follows dispense end or start, by apply mode.
// - Touchdown event taken on the rising or falling sensor edge, selectable.
// - Touchdown wait limit acts as touchdown on expiry, no error raised.
// - Applicator logic acts only while applicator signalling mode is chosen.
// - Start input read as falling, rising, both edges, or low/high level.
//
// Decided for this implementation: the placing of the registers and the APB register port.

`timescale 1ns/1ns

module label_applicator_sequencer #(
	parameter int TICK_CYCLES = sequencer_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Labeler side
	input  wire logic        start_in,
	input  wire logic        dispense_done_in,
	input  wire logic        warning_in,
	output logic             dispense_req,
	// Applicator sensors
	input  wire logic        touchdown_in,
	input  wire logic        home_pos_in,
	input  wire logic        end_pos_in,
	// Applicator valves and signal lines
	output logic             cylinder_extend,
	output logic             vacuum_out,
	output logic             blow_valve,
	output logic             dwell_out,
	output logic             status_line_a,
	output logic             status_line_b,
	output logic             position_error
);
	import sequencer_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             start_s1;
		logic             start_s2;
		logic             start_s3;
		logic             td_s1;
		logic             td_s2;
		logic             td_s3;
		logic [PRE_W-1:0] pre;
		logic             tick;
		seq_state_t       state;
		logic [MSW-1:0]   ph_ms;
		logic [MSW-1:0]   pos_ms;
		logic [MSW-1:0]   lock_ms;
		logic             pos_err;
		appl_type_t       atype;
		logic             apply_sf;
		logic             stat_sel;
		logic             td_rise;
		start_mode_t      smode;
		logic             applic;
		logic [MSW-1:0]   dwell;
		logic [MSW-1:0]   blow;
		logic [MSW-1:0]   restart;
		logic [MSW-1:0]   posto;
		logic [MSW-1:0]   comp;
		logic [MSW-1:0]   tdto;
		logic [31:0]      prdata;
		logic             disp_req;
		logic             disp_end;
		logic             cyl;
		logic             vac;
		logic             blow_o;
		logic             dwell_o;
		logic             line_a;
		logic             line_b;
	} st_t;

	localparam st_t ST_RST = '{
		state:   ST_IDLE,
		atype:   AT_DIRECT,
		smode:   SM_FALL,
		applic:  APPLIC_DEF,
		dwell:   DWELL_DEF,
		blow:    BLOW_DEF,
		restart: RESTART_DEF,
		posto:   POSTO_DEF,
		comp:    COMP_DEF,
		tdto:    TDTO_DEF,
		default: '0
	};

	st_t r;
	st_t n;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == CTRL_OFS) || (a == DWELL_TIME_OFS) ||
			(a == BLOW_TIME_OFS) || (a == RESTART_DELAY_OFS) ||
			(a == POSITION_LIMIT_OFS) || (a == STROKE_COMP_OFS) ||
			(a == CONTACT_WAIT_LIMIT_OFS) || (a == STATUS_OFS);
	endfunction

	function automatic logic [MSW-1:0] ms_inc(input logic [MSW-1:0] v, input logic t);
		ms_inc = (t && v != MS_SAT) ? MSW'(v + 17'h00001) : v;
	endfunction

	function automatic logic [MSW-1:0] clamp(input logic [MSW-1:0] v,
			input logic [MSW-1:0] lo, input logic [MSW-1:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic is_timed(input appl_type_t t);
		is_timed = (t == AT_TIMED) || (t == AT_TIMED_BLOW) || (t == AT_REJECT_SEP) ||
			(t == AT_TAMP_TIMED) || (t == AT_TAMP_BO_TIMED);
	endfunction

	function automatic logic blow_only(input appl_type_t t);
		blow_only = (t == AT_LEGACY_BLOW) || (t == AT_AIR_BLOW);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic             start_ev;
	logic             td_ev;
	logic             locked;
	logic             wr;
	logic             seq_rst;
	logic             finish;
	logic [3:0]       caps;
	logic [MSW-1:0]   wv;
	seq_state_t       ns;
	appl_type_t       wtype;

	always_comb begin
		n = r;
		finish = 1'b0;
		caps = type_caps(r.atype);
		wv = pwdata[MSW-1:0];
		wtype = (pwdata[CTRL_TYPE_LSB+3:CTRL_TYPE_LSB] > 4'hd) ? AT_DIRECT :
			appl_type_t'(pwdata[CTRL_TYPE_LSB+3:CTRL_TYPE_LSB]);

		// Only s2/s3 feed the edge logic; s1 settles metastability
		n.start_s1 = start_in;
		n.start_s2 = r.start_s1;
		n.start_s3 = r.start_s2;
		n.td_s1 = touchdown_in;
		n.td_s2 = r.td_s1;
		n.td_s3 = r.td_s2;

		if (r.pre >= PRE_W'(TICK_CYCLES - 1)) begin
			n.pre = '0;
			n.tick = 1'b1;
		end else begin
			n.pre = PRE_W'(r.pre + 20'h00001);
			n.tick = 1'b0;
		end
		n.ph_ms = ms_inc(r.ph_ms, r.tick);
		n.pos_ms = ms_inc(r.pos_ms, r.tick);
		n.lock_ms = ms_inc(r.lock_ms, r.tick);

		unique case (r.smode)
			SM_LEVEL_LOW: start_ev = !r.start_s2;
			SM_RISE:      start_ev = r.start_s2 && !r.start_s3;
			SM_LEVEL_HI:  start_ev = r.start_s2;
			SM_BOTH:      start_ev = r.start_s2 != r.start_s3;
			default:      start_ev = !r.start_s2 && r.start_s3;
		endcase
		td_ev = r.td_rise ? (r.td_s2 && !r.td_s3) : (!r.td_s2 && r.td_s3);
		locked = caps[1] && (r.lock_ms < r.restart);

		// --------------------------------------------------------
		// Register writes
		// --------------------------------------------------------
		wr = psel && penable && pwrite && addr_hit(paddr);
		seq_rst = wr && (paddr == CTRL_OFS) && pwdata[CTRL_SEQ_RST];
		if (wr) begin
			unique case (paddr)
				CTRL_OFS: begin
					n.atype = wtype;
					n.apply_sf = pwdata[CTRL_APPLY_SF];
					n.stat_sel = pwdata[CTRL_STAT_SEL];
					n.td_rise = pwdata[CTRL_TD_RISE];
					n.smode = (pwdata[CTRL_SMODE_LSB+2:CTRL_SMODE_LSB] > 3'h4) ? SM_FALL :
						start_mode_t'(pwdata[CTRL_SMODE_LSB+2:CTRL_SMODE_LSB]);
					n.applic = pwdata[CTRL_APPLIC];
					// A new type reloads its own dwell and blow defaults
					if (wtype != r.atype) begin
						n.dwell = (wtype == AT_TAMP_TIMED) ? DWELL_TAMP_DEF : DWELL_DEF;
						n.blow = (wtype == AT_AIR_BLOW) ? BLOW_AIR_DEF : BLOW_DEF;
					end
				end
				DWELL_TIME_OFS:     n.dwell = clamp(wv, DWELL_MIN, MS_MAX);
				BLOW_TIME_OFS:      n.blow = clamp(wv, MS_ZERO, MS_MAX);
				RESTART_DELAY_OFS:  n.restart = clamp(wv, MS_ZERO, MS_MAX);
				POSITION_LIMIT_OFS: n.posto = clamp(wv, POSTO_MIN, MS_MAX);
				STROKE_COMP_OFS:    n.comp = clamp(wv, MS_ZERO, MS_MAX);
				CONTACT_WAIT_LIMIT_OFS:
					n.tdto = (wv == MS_ZERO) ? MS_ZERO : clamp(wv, TDTO_MIN, MS_MAX);
				STATUS_OFS:
					if (pwdata[STAT_POS_ERR]) begin
						n.pos_err = 1'b0;
					end
				default: ;
			endcase
		end

		// --------------------------------------------------------
		// Sequencer
		// --------------------------------------------------------
		ns = r.state;
		unique case (r.state)
			ST_IDLE: begin
				if (r.atype == REVERSE_WAIT_BLOW_TYPE) begin
					ns = ST_PARK_MOVE;
				end else if (start_ev && !locked) begin
					if (r.atype == AT_DIRECT || !r.apply_sf) begin
						ns = ST_DISPENSE;
					end else begin
						ns = ST_COMP;
					end
				end
			end
			ST_DISPENSE: begin
				if (dispense_done_in) begin
					if (r.atype == REVERSE_WAIT_BLOW_TYPE) begin
						ns = ST_PARK_MOVE;
					end else if (r.atype == AT_DIRECT || r.apply_sf) begin
						ns = ST_IDLE;
						n.lock_ms = (r.atype == AT_DIRECT) ? MS_ZERO : n.lock_ms;
					end else begin
						ns = ST_COMP;
					end
				end
			end
			ST_COMP: begin
				if (r.ph_ms >= r.comp) begin
					ns = blow_only(r.atype) ? ST_BLOW : ST_EXTEND;
				end
			end
			ST_EXTEND: begin
				if (is_timed(r.atype)) begin
					if (caps[0] && !end_pos_in && r.pos_ms >= r.posto) begin
						n.pos_err = 1'b1;
						ns = ST_RETRACT;
					end else if (r.ph_ms >= r.dwell) begin
						ns = (caps[2] && r.blow != MS_ZERO) ? ST_BLOW : ST_RETRACT;
					end
				end else if (td_ev || (r.tdto != MS_ZERO && r.ph_ms >= r.tdto)) begin
					ns = (caps[2] && r.blow != MS_ZERO) ? ST_BLOW : ST_RETRACT;
				end
			end
			ST_BLOW: begin
				if (r.ph_ms >= r.blow) begin
					if (blow_only(r.atype)) begin
						finish = 1'b1;
					end else begin
						ns = ST_RETRACT;
					end
				end
			end
			ST_RETRACT: begin
				if (home_pos_in || (caps[0] && r.pos_ms >= r.posto)) begin
					if (!home_pos_in) begin
						n.pos_err = 1'b1;
					end
					if (r.atype == REVERSE_WAIT_BLOW_TYPE) begin
						ns = ST_DISPENSE;
						n.lock_ms = MS_ZERO;
					end else begin
						finish = 1'b1;
					end
				end
			end
			ST_PARK_MOVE: begin
				if (end_pos_in || (caps[0] && r.pos_ms >= r.posto)) begin
					if (!end_pos_in) begin
						n.pos_err = 1'b1;
					end
					ns = ST_PARKED;
				end
			end
			ST_PARKED: begin
				if (r.atype != REVERSE_WAIT_BLOW_TYPE) begin
					ns = ST_RETRACT;
				end else if (start_ev && !locked) begin
					ns = ST_BLOW;
				end
			end
			default: ns = ST_IDLE;
		endcase
		if (finish) begin
			n.lock_ms = MS_ZERO;
			ns = r.apply_sf ? ST_DISPENSE : ST_IDLE;
		end
		if (!r.applic || seq_rst) begin
			ns = ST_IDLE;
		end
		n.state = ns;
		if (ns != r.state) begin
			n.ph_ms = MS_ZERO;
			n.pos_ms = MS_ZERO;
			n.pre = '0;
			n.tick = 1'b0;
		end

		// --------------------------------------------------------
		// Registered pin outputs, from the next state
		// --------------------------------------------------------
		n.disp_req = (ns == ST_DISPENSE);
		if (ns == ST_DISPENSE) begin
			n.disp_end = 1'b0;
		end else if (r.state == ST_DISPENSE && dispense_done_in) begin
			n.disp_end = 1'b1;
		end
		n.cyl = (ns == ST_EXTEND) || (ns == ST_PARK_MOVE) || (ns == ST_PARKED) ||
			(ns == ST_BLOW && !blow_only(r.atype));
		n.dwell_o = (ns == ST_EXTEND) && is_timed(r.atype);
		n.vac = (r.atype == AT_SENS_LIMIT) && r.applic && (ns == ST_IDLE ||
			ns == ST_DISPENSE || ns == ST_COMP || ns == ST_EXTEND);
		n.blow_o = (ns == ST_BLOW);
		n.line_a = r.stat_sel ? n.disp_end : n.vac;
		n.line_b = r.stat_sel ? warning_in : n.blow_o;

		// --------------------------------------------------------
		// Read data, captured in the setup phase
		// --------------------------------------------------------
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CTRL_OFS: n.prdata = {20'h00000, 1'b0, r.applic, r.smode, r.td_rise,
					r.stat_sel, r.apply_sf, r.atype};
				DWELL_TIME_OFS:         n.prdata = {15'h0000, r.dwell};
				BLOW_TIME_OFS:          n.prdata = {15'h0000, r.blow};
				RESTART_DELAY_OFS:      n.prdata = {15'h0000, r.restart};
				POSITION_LIMIT_OFS:     n.prdata = {15'h0000, r.posto};
				STROKE_COMP_OFS:        n.prdata = {15'h0000, r.comp};
				CONTACT_WAIT_LIMIT_OFS: n.prdata = {15'h0000, r.tdto};
				STATUS_OFS: n.prdata = {25'h0000000, r.disp_end, locked, r.pos_err,
					r.state};
				default:                n.prdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= ST_RST;
		end else begin
			r <= n;
		end
	end

	// Zero wait states: one access cycle always completes
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit(paddr);
	assign prdata = r.prdata;
	assign dispense_req = r.disp_req;
	assign cylinder_extend = r.cyl;
	assign vacuum_out = r.vac;
	assign blow_valve = r.blow_o;
	assign dwell_out = r.dwell_o;
	assign status_line_a = r.line_a;
	assign status_line_b = r.line_b;
	assign position_error = r.pos_err;

endmodule // label_applicator_sequencer

// ==== hdl/sequencer_pkg.sv ====
// Constants, encodings and lookups for the label applicator sequencer.
// Assumes a 100 MHz pclk and 32-bit APB register access.

package sequencer_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TICK_PERIOD_NS  = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PRE_W           = 20;
	localparam int MSW             = 17;

	// ----------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS               = 8'h00;
	localparam logic [7:0] DWELL_TIME_OFS         = 8'h04;
	localparam logic [7:0] BLOW_TIME_OFS          = 8'h08;
	localparam logic [7:0] RESTART_DELAY_OFS      = 8'h0c;
	localparam logic [7:0] POSITION_LIMIT_OFS     = 8'h10;
	localparam logic [7:0] STROKE_COMP_OFS        = 8'h14;
	localparam logic [7:0] CONTACT_WAIT_LIMIT_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS             = 8'h1c;

	localparam int CTRL_TYPE_LSB  = 0;
	localparam int CTRL_APPLY_SF  = 4;
	localparam int CTRL_STAT_SEL  = 5;
	localparam int CTRL_TD_RISE   = 6;
	localparam int CTRL_SMODE_LSB = 7;
	localparam int CTRL_APPLIC    = 10;
	localparam int CTRL_SEQ_RST   = 11;
	localparam int STAT_POS_ERR   = 4;
	localparam int STAT_LOCKED    = 5;
	localparam int STAT_DISP_END  = 6;

	// ----------------------------------------------------------------
	// Values after reset and ranges, in ms
	// ----------------------------------------------------------------
	localparam logic [MSW-1:0] DWELL_DEF      = 17'h000c8;
	localparam logic [MSW-1:0] DWELL_TAMP_DEF = 17'h001f4;
	localparam logic [MSW-1:0] BLOW_DEF       = 17'h00032;
	localparam logic [MSW-1:0] BLOW_AIR_DEF   = 17'h0003c;
	localparam logic [MSW-1:0] RESTART_DEF    = 17'h00000;
	localparam logic [MSW-1:0] POSTO_DEF      = 17'h007d0;
	localparam logic [MSW-1:0] COMP_DEF       = 17'h00000;
	localparam logic [MSW-1:0] TDTO_DEF       = 17'h00000;
	localparam logic [MSW-1:0] MS_MAX         = 17'h1869f;
	localparam logic [MSW-1:0] MS_ZERO        = 17'h00000;
	localparam logic [MSW-1:0] DWELL_MIN      = 17'h00001;
	localparam logic [MSW-1:0] POSTO_MIN      = 17'h001f4;
	localparam logic [MSW-1:0] TDTO_MIN       = 17'h00064;
	localparam logic [MSW-1:0] MS_SAT         = 17'h1ffff;
	localparam logic           APPLIC_DEF     = 1'b1;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		AT_SENS_LIMIT          = 4'h0,
		AT_TIMED               = 4'h1,
		AT_TIMED_BLOW          = 4'h2,
		AT_SENS_TERM           = 4'h3,
		AT_LEGACY_BLOW         = 4'h4,
		REVERSE_WAIT_BLOW_TYPE = 4'h5,
		AT_DIRECT              = 4'h6,
		AT_REJECT_SEP          = 4'h7,
		AT_RING                = 4'h8,
		AT_AIR_BLOW            = 4'h9,
		AT_TAMP_TIMED          = 4'ha,
		AT_TAMP_SENSOR         = 4'hb,
		AT_TAMP_BO_TIMED       = 4'hc,
		AT_TAMP_BO_SENSOR      = 4'hd
	} appl_type_t;

	typedef enum logic [2:0] {
		SM_FALL      = 3'h0,
		SM_LEVEL_LOW = 3'h1,
		SM_RISE      = 3'h2,
		SM_LEVEL_HI  = 3'h3,
		SM_BOTH      = 3'h4
	} start_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_DISPENSE  = 4'h1,
		ST_COMP      = 4'h2,
		ST_EXTEND    = 4'h3,
		ST_BLOW      = 4'h4,
		ST_RETRACT   = 4'h5,
		ST_PARK_MOVE = 4'h6,
		ST_PARKED    = 4'h7
	} seq_state_t;

	// Which timers apply per type: {dwell, blow, restart, position}
	function automatic logic [3:0] type_caps(input appl_type_t t);
		unique case (t)
			AT_SENS_LIMIT:          type_caps = 4'h7;
			AT_TIMED:               type_caps = 4'hb;
			AT_TIMED_BLOW:          type_caps = 4'hf;
			AT_SENS_TERM:           type_caps = 4'h7;
			AT_LEGACY_BLOW:         type_caps = 4'h6;
			REVERSE_WAIT_BLOW_TYPE: type_caps = 4'hf;
			AT_DIRECT:              type_caps = 4'h2;
			AT_REJECT_SEP:          type_caps = 4'hf;
			AT_RING:                type_caps = 4'h7;
			AT_AIR_BLOW:            type_caps = 4'h6;
			AT_TAMP_TIMED:          type_caps = 4'hb;
			AT_TAMP_SENSOR:         type_caps = 4'h3;
			AT_TAMP_BO_TIMED:       type_caps = 4'hf;
			AT_TAMP_BO_SENSOR:      type_caps = 4'h7;
		endcase
	endfunction

endpackage

// ==== verif/applicator_model.sv ====
// Behavioural pneumatic applicator: cylinder travel and contact sensor.
// Follows the extend valve; travel time in pclk cycles.
`timescale 1ns/1ns
module applicator_model #(
	parameter int TRAVEL = 4
) (
	input  wire logic pclk,
	input  wire logic cylinder_extend,
	// Fault controls
	input  wire logic no_contact,
	input  wire logic stuck,
	output logic      home_pos_in,
	output logic      end_pos_in,
	output logic      touchdown_in
);
	int pos = 0;
	// A stuck cylinder never gets home, so the home switch stays open
	always @(posedge pclk) begin
		if (cylinder_extend && pos < TRAVEL)
			pos <= pos + 1;
		else if (!cylinder_extend && pos > 0 && !stuck)
			pos <= pos - 1;
	end
	assign home_pos_in  = (pos == 0);
	assign end_pos_in   = (pos == TRAVEL);
	assign touchdown_in = end_pos_in && !no_contact;
endmodule // applicator_model

// ==== verif/seq_checker.sv ====
// Port-level checks for the label applicator sequencer.
// Bound into the top module; sees its ports only.
`timescale 1ns/1ns
module seq_checker #(
	parameter int TICK_CYCLES = 10
) (
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	// Labeler and applicator
	input wire logic        warning_in,
	input wire logic        dispense_done_in,
	input wire logic        dispense_req,
	input wire logic        cylinder_extend,
	input wire logic        vacuum_out,
	input wire logic        blow_valve,
	input wire logic        dwell_out,
	input wire logic        status_line_a,
	input wire logic        status_line_b,
	input wire logic        position_error
);
	logic [3:0] type_r;
	logic       sel_r;
	logic       sel_q;
	wire        wr = psel && penable && pwrite;
	wire        clr = wr && paddr == 8'h1c && pwdata[4];

	// Shadow of the control word, so mapping checks know type and select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_r <= 4'h6;
			sel_r  <= 1'b0;
			sel_q  <= 1'b0;
		end else begin
			sel_q <= sel_r;
			if (wr && paddr == 8'h00) begin
				type_r <= pwdata[3:0];
				sel_r  <= pwdata[5];
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_handoff;
		dispense_req && dispense_done_in;
	endsequence

	chk_reset_quiet: assert property (!$past(presetn) |-> !(cylinder_extend || blow_valve
		|| vacuum_out || dispense_req || dwell_out || position_error))
		else $error("output active after reset");
	chk_bus_err: assert property (psel && penable |->
		pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
		else $error("slave error mismatch");
	chk_status_vac: assert property (!sel_r && !sel_q |->
		status_line_a == vacuum_out && status_line_b == blow_valve)
		else $error("status lines not valve copies");
	chk_status_warn: assert property (sel_r && sel_q |-> status_line_b == $past(warning_in))
		else $error("warning line wrong");
	chk_dwell_ext: assert property (dwell_out |-> cylinder_extend)
		else $error("dwell line without extension");
	chk_dwell_min: assert property ($rose(dwell_out) && TICK_CYCLES >= 8 |-> dwell_out[*8])
		else $error("dwell shorter than a tick");
	chk_req_drop: assert property (s_handoff |=> !dispense_req)
		else $error("dispense request held after done");
	chk_vac_type: assert property (type_r != 4'h0 && $stable(type_r) |-> !vacuum_out)
		else $error("vacuum on wrong type");
	chk_no_stroke: assert property ((type_r == 4'h6 || type_r == 4'h9) |-> !cylinder_extend)
		else $error("stroke on strokeless type");
	chk_err_sticky: assert property (position_error && !clr |=> position_error)
		else $error("position error dropped");
endmodule // seq_checker

bind label_applicator_sequencer seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .pslverr(pslverr), .warning_in(warning_in),
	.dispense_done_in(dispense_done_in), .dispense_req(dispense_req),
	.cylinder_extend(cylinder_extend), .vacuum_out(vacuum_out), .blow_valve(blow_valve),
	.dwell_out(dwell_out), .status_line_a(status_line_a), .status_line_b(status_line_b),
	.position_error(position_error));

// ==== verif/tb.sv ====
// Self-checking bench for the applicator sequencer over APB.
// Uses a short ms tick (10 cycles) and the applicator model.
`timescale 1ns/1ns
module tb;
	import sequencer_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        err, pready, pslverr, start_in = 1, dispense_done_in = 0, warning_in = 0;
	logic        dispense_req, touchdown_in, home_pos_in, end_pos_in, cylinder_extend;
	logic        vacuum_out, blow_valve, dwell_out, status_line_a, status_line_b;
	logic        position_error, no_contact = 0, stuck = 0;
	int          bad_count = 0, checks_done = 0, ext_len, blow_len, dwell_len, lead, disp;
	logic [31:0] dflt [8] = '{32'h406, 32'hc8, 32'h32, 32'h0, 32'h7d0, 32'h0, 32'h0, 32'h0};

	label_applicator_sequencer #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .start_in(start_in),
		.dispense_done_in(dispense_done_in), .warning_in(warning_in),
		.dispense_req(dispense_req), .touchdown_in(touchdown_in), .home_pos_in(home_pos_in),
		.end_pos_in(end_pos_in), .cylinder_extend(cylinder_extend), .vacuum_out(vacuum_out),
		.blow_valve(blow_valve), .dwell_out(dwell_out), .status_line_a(status_line_a),
		.status_line_b(status_line_b), .position_error(position_error));
	applicator_model am (.pclk(pclk), .cylinder_extend(cylinder_extend),
		.no_contact(no_contact), .stuck(stuck), .home_pos_in(home_pos_in),
		.end_pos_in(end_pos_in), .touchdown_in(touchdown_in));

	initial forever #5 pclk = ~pclk;

	// Labeler answers each request with a one-cycle done pulse
	always @(posedge pclk) begin
		dispense_done_in <= dispense_req && !dispense_done_in;
		lead += (ext_len == 0);
		ext_len += cylinder_extend;
		blow_len += blow_valve;
		dwell_len += dwell_out;
		disp += dispense_done_in;
	end

	// ------
	// Bus and check tasks
	// ------
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi, input string m);
		chk(32'(v >= lo && v <= hi), 32'h1, m);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp, m);
	endtask

	task automatic cfg(input logic [31:0] c, input logic [31:0] b);
		apb(CTRL_OFS, 1'b1, c);
		apb(DWELL_TIME_OFS, 1'b1, 32'h3);
		apb(BLOW_TIME_OFS, 1'b1, b);
	endtask

	// Start pulse low then high, then wait until the sequencer rests again
	task automatic fire(input logic [3:0] rest = 4'h0);
		@(negedge pclk);
		ext_len = 0;
		blow_len = 0;
		dwell_len = 0;
		lead = 0;
		disp = 0;
		@(posedge pclk);
		start_in <= 1'b0;
		repeat (4) @(posedge pclk);
		start_in <= 1'b1;
		// Let a rising-edge start reach the sequencer before polling
		repeat (4) @(posedge pclk);
		do apb(STATUS_OFS, 1'b0, 32'h0); while (rd[3:0] !== rest);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------
	// Scenarios
	// ------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rdchk(8'(4 * i), dflt[i], "reset value");
		apb(8'h20, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(DWELL_TIME_OFS, 1'b1, 32'h0);
		rdchk(DWELL_TIME_OFS, 32'h1, "dwell floor");
		apb(POSITION_LIMIT_OFS, 1'b1, 32'h64);
		rdchk(POSITION_LIMIT_OFS, 32'h1f4, "timeout floor");
		apb(CTRL_OFS, 1'b1, 32'h40a);
		rdchk(DWELL_TIME_OFS, 32'h1f4, "tamp dwell");
		apb(CTRL_OFS, 1'b1, 32'h409);
		rdchk(BLOW_TIME_OFS, 32'h3c, "air blow time");
		fire();
		rng(blow_len, 600, 615, "air blow");
		rng(ext_len + dwell_len, 0, 0, "no stroke");
		apb(CTRL_OFS, 1'b1, 32'h406);
		fire();
		rng(disp, 1, 1, "direct label");
		cfg(32'h401, 32'h2);
		fire();
		rng(dwell_len, 30, 41, "dwell");
		rng(ext_len, 30, 45, "timed stroke");
		rng(blow_len, 0, 0, "no blow");
		apb(CTRL_OFS, 1'b1, 32'h501);
		fire();
		rng(lead, 11, 14, "rising start");
		apb(RESTART_DELAY_OFS, 1'b1, 32'h5);
		fire();
		fire();
		rng(ext_len, 0, 0, "locked start");
		apb(RESTART_DELAY_OFS, 1'b1, 32'h0);
		repeat (80) @(posedge pclk);
		cfg(32'h402, 32'h2);
		fire();
		rng(blow_len, 20, 31, "blow after dwell");
		rng(ext_len, 50, 75, "held through blow");
		apb(CTRL_OFS, 1'b1, 32'h422);
		warning_in <= 1'b1;
		repeat (4) @(negedge pclk);
		chk({31'h0, status_line_b}, 32'h1, "warning line");
		chk({31'h0, status_line_a}, 32'h1, "dispense end line");
		cfg(32'h443, 32'h0);
		fire();
		rng(ext_len, 4, 20, "touchdown end");
		apb(CONTACT_WAIT_LIMIT_OFS, 1'b1, 32'h64);
		apb(CTRL_OFS, 1'b1, 32'h403);
		fire();
		rng(ext_len, 1000, 1030, "contact limit");
		chk({31'h0, position_error}, 32'h0, "no error");
		apb(CTRL_OFS, 1'b1, 32'h400);
		repeat (2) @(negedge pclk);
		chk({31'h0, vacuum_out}, 32'h1, "vacuum hold");
		apb(CTRL_OFS, 1'b1, 32'h000);
		repeat (2) @(negedge pclk);
		chk({31'h0, vacuum_out}, 32'h0, "mode off");
		cfg(32'h401, 32'h2);
		stuck <= 1'b1;
		fire();
		chk({31'h0, position_error}, 32'h1, "position error");
		stuck <= 1'b0;
		apb(STATUS_OFS, 1'b1, 32'h10);
		repeat (2) @(negedge pclk);
		chk({31'h0, position_error}, 32'h0, "error cleared");
		cfg(32'h411, 32'h0);
		apb(STROKE_COMP_OFS, 1'b1, 32'h3);
		fire();
		rng(lead, 30, 50, "compensation");
		rng(disp, 1, 1, "next label");
		cfg(32'h405, 32'h2);
		fire(4'h7);
		rng(blow_len, 20, 31, "parked blow");
		rng(disp, 1, 1, "reverse reload");
		complete_run();
	end

	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		complete_run();
	end
endmodule // tb
